// >>> remote_uart.sv
// Behavioural far-end transceiver for the second serial channel.
// Assumes the line idles high through a pull-up and that bit_clks holds
// still for the length of a frame.
`timescale 1ns/1ps
module remote_uart
(
   input wire logic clk,
   input wire logic line_in,
   input wire logic [15:0] bit_clks,
   output logic line_out
);
   logic [7:0] last_rx;
   int rx_count;
   ////////////////////////////////////////////////////////////////////////////
   // Idle line high, as a released line with a pull-up would sit
   initial
   begin
      line_out = 1'b1;
      rx_count = 0;
      last_rx = 8'h00;
   end
   // Start bit, eight data bits LSB first, one stop bit
   task automatic send_byte(input logic [7:0] d);
      int i;
      begin
         @(posedge clk);
         line_out <= 1'b0;
         repeat (bit_clks) @(posedge clk);
         for (i = 0; i < 8; i++)
         begin
            line_out <= d[i];
            repeat (bit_clks) @(posedge clk);
         end
         line_out <= 1'b1;
         repeat (bit_clks) @(posedge clk);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Mid-bit sampling; a glitch shorter than half a bit is not a start
   always
   begin
      wait (line_in === 1'b1);
      wait (line_in === 1'b0);
      repeat (bit_clks / 2) @(posedge clk);
      if (line_in === 1'b0)
      begin
         for (int j = 0; j < 8; j++)
         begin
            repeat (bit_clks) @(posedge clk);
            last_rx[j] = line_in;
         end
         repeat (bit_clks) @(posedge clk);
         rx_count++;
      end
   end
endmodule

// >>> testbench.sv
// Self-checking bench for the serial channel with clock-source selection.
// Assumes the design header, package and the far-end model are compiled.
`timescale 1ns/1ps
`include "uart_clksel_defines.svh"
module testbench;
   import uart_clksel_pkg::*;
   logic clk, resetn, ce, avs_waitrequest;
   avs_req_type avs_req;
   logic [31:0] avs_readdata;
   logic txd_pin, txd_pin_oe, port_txd_value, port_txd_oe, port_rxd_value;
   logic rxd_line;
   logic [1:0] tick_r;
   logic [15:0] bit_clks;
   logic [7:0] rd;
   int mismatches, total_checks;
   // A released transmit line is held high by the pull-up
   wire tx_line = txd_pin_oe ? txd_pin : 1'b1;
   ////////////////////////////////////////////////////////////////////////////
   uart_clksel uart_clksel_i (.clk(clk), .resetn(resetn), .ce(ce),
      .avs_req(avs_req), .avs_waitrequest(avs_waitrequest),
      .avs_readdata(avs_readdata), .external_serial_clock_pin(tick_r[1]),
      .second_timer(tick_r[0]), .rxd_pin(rxd_line), .txd_pin(txd_pin),
      .txd_pin_oe(txd_pin_oe), .port_txd_value(port_txd_value),
      .port_txd_oe(port_txd_oe), .port_rxd_value(port_rxd_value));
   remote_uart remote_uart_i (.clk(clk), .line_in(tx_line),
      .bit_clks(bit_clks), .line_out(rxd_line));
   ////////////////////////////////////////////////////////////////////////////
   // Clock, and slow source clocks: external every 4 cycles, timer every 2
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
      tick_r <= tick_r + 2'h1;
   // Watchdog well past the expected run of about 33k cycles
   initial
   begin
      #1800000;
      mismatches++;
      tally_and_finish;
   end
   ////////////////////////////////////////////////////////////////////////////
   task tally_and_finish;
      begin
         if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One Avalon access; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [31:0] a,
      input logic [7:0] d, output logic [7:0] q);
      begin
         avs_req.read <= ~wr;
         avs_req.write <= wr;
         avs_req.address <= a;
         avs_req.writedata <= {24'h000000, d};
         @(posedge clk);
         // Only the watchdog ends a wait that never gets its answer
         while (avs_waitrequest !== 1'b0)
            @(posedge clk);
         q = avs_readdata[7:0];
         avs_req.read <= 1'b0;
         avs_req.write <= 1'b0;
         @(posedge clk);
      end
   endtask
   task automatic wr8(input logic [31:0] a, input logic [7:0] d);
      bus(1'b1, a, d, rd);
   endtask
   task automatic chk_rd(input logic [31:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00, rd);
      check_byte(rd, exp);
   endtask
   // Full-duplex byte exchange at a chosen source and divisor
   task automatic xfer(input logic [7:0] sel, input logic [7:0] div,
      input logic [15:0] clks, input logic [7:0] txb, input logic [7:0] rxb);
      int n, k;
      begin
         n = remote_uart_i.rx_count;
         k = 0;
         bit_clks <= clks;
         wr8(`IDX_SERIAL_CLOCK_SOURCE_SELECT, sel);
         wr8(`IDX_BAUD_DIVISOR, div);
         fork
            remote_uart_i.send_byte(rxb);
            wr8(`IDX_TX_DATA, txb);
         join
         while (remote_uart_i.rx_count == n && k < 12 * clks)
         begin
            @(posedge clk);
            k++;
         end
         repeat (2 * clks) @(posedge clk);
         chk_rd(`IDX_CHANNEL_STATUS, 8'h06);
         chk_rd(`IDX_RX_DATA, rxb);
         check_byte(remote_uart_i.last_rx, txb);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      resetn = 1'b0;
      ce = 1'b1;
      avs_req = '0;
      avs_req.byteenable = 4'hF;
      port_txd_value = 1'b1;
      port_txd_oe = 1'b0;
      tick_r = 2'h0;
      bit_clks = 16'h0010;
      mismatches = 0;
      total_checks = 0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chk_rd(`IDX_SERIAL_MODE_CONTROL, 8'h00);
      chk_rd(`IDX_SERIAL_CLOCK_SOURCE_SELECT, 8'h00);
      chk_rd(`IDX_BAUD_DIVISOR, `RST_BAUD_DIVISOR);
      chk_rd(32'h00000010, 8'h00);
      wr8(`IDX_SERIAL_CLOCK_SOURCE_SELECT, 8'hFF);
      chk_rd(`IDX_SERIAL_CLOCK_SOURCE_SELECT, 8'h07);
      // Stopped: transmit pin follows the port
      port_txd_value <= 1'b0;
      port_txd_oe <= 1'b1;
      repeat (3) @(posedge clk);
      check_bit(txd_pin, 1'b0);
      check_bit(txd_pin_oe, 1'b1);
      port_txd_oe <= 1'b0;
      wr8(`IDX_SERIAL_CLOCK_SOURCE_SELECT, 8'h01);
      wr8(`IDX_BAUD_DIVISOR, 8'h01);
      // Stopped: receive pin readable as a port, no byte collected
      fork
         remote_uart_i.send_byte(8'h5A);
         begin
            repeat (8) @(posedge clk);
            check_bit(port_rxd_value, 1'b0);
         end
      join
      wr8(`IDX_TX_DATA, 8'h11);
      chk_rd(`IDX_CHANNEL_STATUS, 8'h00);
      // Every enable combination; only both zero is stopped
      for (int m = 0; m < 4; m++)
      begin
         wr8(`IDX_SERIAL_MODE_CONTROL, {m[1:0], 6'h00});
         repeat (3) @(posedge clk);
         check_bit(txd_pin_oe, m[1]);
         chk_rd(`IDX_CHANNEL_STATUS, {5'h00, |m[1:0], 2'b00});
         chk_rd(`IDX_SERIAL_MODE_CONTROL, {m[1:0], 6'h00});
      end
      // Each internal division, then external pin, timer and 31.25 kbps
      for (int k = 1; k <= 6; k++)
         xfer(k[7:0], 8'h01, 16'(16 << (k - 1)), 8'hA5 ^ k[7:0],
            8'h3C + k[7:0]);
      xfer(8'h00, 8'h01, 16'd64, 8'h81, 8'h7E);
      xfer(8'h07, 8'h01, 16'd32, 8'h0F, 8'hF0);
      xfer(8'h01, 8'h64, 16'd1600, 8'h96, 8'h69);
      // Back to stop: pins return to the port
      wr8(`IDX_SERIAL_MODE_CONTROL, 8'h00);
      chk_rd(`IDX_CHANNEL_STATUS, 8'h00);
      check_bit(txd_pin_oe, 1'b0);
      tally_and_finish;
   end
endmodule

// >>> uart_clksel.sv
// Second serial channel: source-clock selection, rate generator, stop mode
// and a full-duplex byte transmitter and receiver behind Avalon-MM.
// Assumes one clock, a word-addressed Avalon-MM master and pins that come
// from outside the clock domain.
`timescale 1ns/1ps
`include "uart_clksel_defines.svh"
module uart_clksel
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   input wire uart_clksel_pkg::avs_req_type avs_req,
   output logic avs_waitrequest,
   output logic [31:0] avs_readdata,
   input wire logic external_serial_clock_pin,
   input wire logic second_timer,
   input wire logic rxd_pin,
   output logic txd_pin,
   output logic txd_pin_oe,
   input wire logic port_txd_value,
   input wire logic port_txd_oe,
   output logic port_rxd_value
);
   import uart_clksel_pkg::*;

   logic [7:1] mode_ctl_r;
   logic [2:0] clk_sel_r;
   logic [7:0] divisor_r;
   logic ack_r;
   logic [31:0] rdata_nxt;
   logic hit_mode;
   logic hit_sel;
   logic hit_div;
   logic hit_tx;
   logic hit_rx;
   logic hit_stat;
   logic wr_go;
   logic rd_go;
   chan_mode_type mode;
   logic tx_en;
   logic rx_en;
   logic ext_s1_r;
   logic ext_s2_r;
   logic ext_d_r;
   logic rxd_s1_r;
   logic rxd_s2_r;
   logic tm_d_r;
   logic [4:0] pre_cnt_r;
   logic [4:0] pre_mask;
   logic src_tick;
   logic [7:0] div_cnt_r;
   logic os_tick;
   tx_state_type tx_state_r;
   logic [9:0] tx_shift_r;
   logic [3:0] tx_bit_r;
   logic [3:0] tx_sub_r;
   logic [7:0] tx_hold_r;
   logic tx_pend_r;
   rx_state_type rx_state_r;
   logic [3:0] rx_sub_r;
   logic [2:0] rx_bit_r;
   logic [7:0] rx_shift_r;
   logic [7:0] rx_data_r;
   logic rx_valid_r;
   logic rx_done;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode and mode
   ////////////////////////////////////////////////////////////////////////

   // Word-addressed decode; only byte lane 0 carries the 8-bit registers
   assign hit_mode = avs_req.address == `IDX_SERIAL_MODE_CONTROL;
   assign hit_sel = avs_req.address == `IDX_SERIAL_CLOCK_SOURCE_SELECT;
   assign hit_div = avs_req.address == `IDX_BAUD_DIVISOR;
   assign hit_tx = avs_req.address == `IDX_TX_DATA;
   assign hit_rx = avs_req.address == `IDX_RX_DATA;
   assign hit_stat = avs_req.address == `IDX_CHANNEL_STATUS;
   assign wr_go = ce && avs_req.write && ack_r && avs_req.byteenable[0];
   assign rd_go = ce && avs_req.read && ack_r;

   // Stopped exactly when both enables are clear
   assign tx_en = mode_ctl_r[`POS_TX_ENABLE_BIT];
   assign rx_en = mode_ctl_r[`POS_RX_ENABLE_BIT];
   assign mode = (tx_en || rx_en) ? MODE_ASYNC : MODE_STOPPED;

   // One wait state: the answer stands on the edge after the request
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         ack_r <= 1'b0;
      else if (ce)
         ack_r <= (avs_req.read || avs_req.write) && !ack_r;
   end

   // Waitrequest is its own flop, the inverse of the next acknowledge
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         avs_waitrequest <= 1'b1;
      else if (ce)
         avs_waitrequest <= !((avs_req.read || avs_req.write) && !ack_r);
   end

   // Read mux; unmapped words and upper lanes read as zero
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      if (hit_mode)
         rdata_nxt[7:0] = {mode_ctl_r, 1'b0};
      else if (hit_sel)
         rdata_nxt[7:0] = {5'h00, clk_sel_r};
      else if (hit_div)
         rdata_nxt[7:0] = divisor_r;
      else if (hit_rx)
         rdata_nxt[7:0] = rx_data_r;
      else if (hit_stat)
      begin
         rdata_nxt[`POS_STAT_TX_BUSY] = tx_pend_r || (tx_state_r != TX_IDLE);
         rdata_nxt[`POS_STAT_RX_VALID] = rx_valid_r;
         rdata_nxt[`POS_STAT_ACTIVE] = mode == MODE_ASYNC;
      end
   end

   // Read data is registered so it stands together with the answer
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         avs_readdata <= 32'h0000_0000;
      else if (ce && avs_req.read && !ack_r)
         avs_readdata <= rdata_nxt;
   end

   // Mode register; bit 0 is not stored and always reads zero
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         mode_ctl_r <= 7'(`RST_SERIAL_MODE_CONTROL >> 1);
      else if (wr_go && hit_mode)
         mode_ctl_r <= avs_req.writedata[7:1];
   end

   // Clock-source select, cleared to the external pin by reset
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         clk_sel_r <= `RST_SERIAL_CLOCK_SOURCE_SELECT;
      else if (wr_go && hit_sel)
         clk_sel_r <= avs_req.writedata[2:0];
   end

   // Divisor of the selected source down to sixteen ticks per bit
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         divisor_r <= `RST_BAUD_DIVISOR;
      else if (wr_go && hit_div)
         divisor_r <= avs_req.writedata[7:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // Source clock selection and rate generator
   ////////////////////////////////////////////////////////////////////////

   // External clock and receive pins cross through two flops; the timer input only gets one delay flop
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
         ext_d_r <= 1'b0;
         rxd_s1_r <= 1'b1;
         rxd_s2_r <= 1'b1;
         tm_d_r <= 1'b0;
      end
      else if (ce)
      begin
         ext_s1_r <= external_serial_clock_pin;
         ext_s2_r <= ext_s1_r;
         ext_d_r <= ext_s2_r;
         rxd_s1_r <= rxd_pin;
         rxd_s2_r <= rxd_s1_r;
         tm_d_r <= second_timer;
      end
   end

   // Prescaler runs only while the channel is active, to save power
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         pre_cnt_r <= 5'h00;
      else if (ce && mode == MODE_ASYNC)
         pre_cnt_r <= pre_cnt_r + 5'h01;
   end

   // Codes 1..6 give fxx/1..fxx/32 by a growing mask on the prescaler
   assign pre_mask = 5'h1F >> (`SRC_DIV_TOP - clk_sel_r);

   always_comb
   begin
      src_tick = 1'b0;
      if (mode == MODE_ASYNC)
      begin
         unique case (clk_sel_r)
            `SRC_EXTERNAL: src_tick = ext_s2_r && !ext_d_r;
            `SRC_TIMER: src_tick = second_timer && !tm_d_r;
            default: src_tick = (pre_cnt_r & pre_mask) == pre_mask;
         endcase
      end
   end

   // Divider: fxx/1 with divisor 100 gives 31.25 kbps at 16x sampling
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         div_cnt_r <= 8'h00;
      else if (ce && mode == MODE_STOPPED)
         div_cnt_r <= 8'h00;
      else if (ce && src_tick)
      begin
         if (div_cnt_r == 8'h00)
            div_cnt_r <= (divisor_r == 8'h00) ? 8'h00 : divisor_r - 8'h01;
         else
            div_cnt_r <= div_cnt_r - 8'h01;
      end
   end

   assign os_tick = ce && src_tick && (div_cnt_r == 8'h00);

   ////////////////////////////////////////////////////////////////////////
   // Transmitter
   ////////////////////////////////////////////////////////////////////////

   // Hold register; a write while busy is dropped, status shows busy
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_pend_r <= 1'b0;
         tx_hold_r <= 8'h00;
      end
      else if (ce)
      begin
         if (!tx_en)
            tx_pend_r <= 1'b0;
         else if (wr_go && hit_tx && !tx_pend_r && tx_state_r == TX_IDLE)
         begin
            tx_pend_r <= 1'b1;
            tx_hold_r <= avs_req.writedata[7:0];
         end
         else if (os_tick && tx_state_r == TX_IDLE)
            tx_pend_r <= 1'b0;
      end
   end

   // Frame is start, eight data bits LSB first, stop; shifted out LSB first
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_state_r <= TX_IDLE;
         tx_shift_r <= 10'h3FF;
         tx_bit_r <= 4'h0;
         tx_sub_r <= 4'h0;
      end
      else if (ce && !tx_en)
      begin
         tx_state_r <= TX_IDLE;
         tx_shift_r <= 10'h3FF;
      end
      else if (os_tick)
      begin
         unique case (tx_state_r)
            TX_IDLE:
               if (tx_pend_r)
               begin
                  tx_state_r <= TX_SHIFT;
                  tx_shift_r <= {1'b1, tx_hold_r, 1'b0};
                  tx_bit_r <= 4'h0;
                  tx_sub_r <= 4'h0;
               end
            TX_SHIFT:
            begin
               tx_sub_r <= tx_sub_r + 4'h1;
               if (tx_sub_r == `OVERSAMPLE_LAST)
               begin
                  tx_shift_r <= {1'b1, tx_shift_r[9:1]};
                  tx_bit_r <= tx_bit_r + 4'h1;
                  if (tx_bit_r == 4'h9)
                     tx_state_r <= TX_IDLE;
               end
            end
            default: tx_state_r <= TX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receiver
   ////////////////////////////////////////////////////////////////////////

   // Start is confirmed at mid-bit, data sampled every sixteen ticks after
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_state_r <= RX_IDLE;
         rx_sub_r <= 4'h0;
         rx_bit_r <= 3'h0;
         rx_shift_r <= 8'h00;
      end
      else if (ce && !rx_en)
         rx_state_r <= RX_IDLE;
      else if (os_tick)
      begin
         rx_sub_r <= rx_sub_r + 4'h1;
         unique case (rx_state_r)
            RX_IDLE:
               if (!rxd_s2_r)
               begin
                  rx_state_r <= RX_START;
                  rx_sub_r <= 4'h0;
               end
            RX_START:
               if (rx_sub_r == `OVERSAMPLE_MID)
               begin
                  rx_state_r <= rxd_s2_r ? RX_IDLE : RX_DATA;
                  rx_sub_r <= 4'h0;
                  rx_bit_r <= 3'h0;
               end
            RX_DATA:
               if (rx_sub_r == `OVERSAMPLE_LAST)
               begin
                  rx_shift_r <= {rxd_s2_r, rx_shift_r[7:1]};
                  rx_bit_r <= rx_bit_r + 3'h1;
                  if (rx_bit_r == `DATA_BITS_LAST)
                     rx_state_r <= RX_STOP;
               end
            RX_STOP:
               if (rx_sub_r == `OVERSAMPLE_LAST)
                  rx_state_r <= RX_IDLE;
         endcase
      end
   end

   assign rx_done = os_tick && rx_state_r == RX_STOP &&
                    rx_sub_r == `OVERSAMPLE_LAST;

   // Received byte; a new byte in the cycle of the clearing read wins
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_data_r <= 8'h00;
         rx_valid_r <= 1'b0;
      end
      else if (rx_done)
      begin
         rx_data_r <= rx_shift_r;
         rx_valid_r <= 1'b1;
      end
      else if (rd_go && hit_rx)
         rx_valid_r <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin ownership
   ////////////////////////////////////////////////////////////////////////

   // Disabled direction hands its pin to the port logic
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         txd_pin <= 1'b1;
         txd_pin_oe <= 1'b0;
         port_rxd_value <= 1'b1;
      end
      else if (ce)
      begin
         txd_pin <= tx_en ? tx_shift_r[0] : port_txd_value;
         txd_pin_oe <= tx_en ? 1'b1 : port_txd_oe;
         port_rxd_value <= rxd_s2_r; // Port read works in both modes
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   ////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_sel_write_lands: assert property (ce && wr_go && hit_sel |=>
      clk_sel_r == $past(avs_req.writedata[2:0]))
      else $error("clock select write lost");
   a_stop_no_tick: assert property (mode == MODE_STOPPED |-> !os_tick)
      else $error("rate tick while stopped");
   a_stop_freeze_pre: assert property (ce && mode == MODE_STOPPED |=>
      $stable(pre_cnt_r))
      else $error("prescaler ran while stopped");
   a_stop_pin_port: assert property (ce && !tx_en |=>
      txd_pin_oe == $past(port_txd_oe) && txd_pin == $past(port_txd_value))
      else $error("transmit pin not handed to port");
   a_tx_drives_pin: assert property (ce && tx_en ##1 ce && tx_en |=>
      txd_pin_oe)
      else $error("transmit pin not driven in serial use");
   a_div1_every_cycle: assert property (mode == MODE_ASYNC &&
      clk_sel_r == 3'h1 |-> src_tick)
      else $error("fxx source not every cycle");
   a_div2_alternate: assert property (ce && mode == MODE_ASYNC &&
      clk_sel_r == 3'h2 && src_tick ##1 ce |-> !src_tick)
      else $error("fxx/2 source ticks back to back");
   a_start_bit_low: assert property (os_tick && tx_state_r == TX_IDLE &&
      tx_pend_r && tx_en |=> tx_shift_r[0] == 1'b0)
      else $error("frame does not begin with a start bit");
   a_rx_valid_set: assert property (rx_done |=> rx_valid_r)
      else $error("received byte not flagged");
   a_ack_one_cycle: assert property (!avs_waitrequest && ce |=>
      avs_waitrequest)
      else $error("answer held longer than one cycle");

   c_async_full_duplex: cover property (tx_state_r == TX_SHIFT &&
      rx_state_r == RX_DATA);
   c_rx_byte_done: cover property (rx_done);
   c_stop_after_run: cover property (mode == MODE_ASYNC ##1
      mode == MODE_STOPPED);
   c_timer_source: cover property (clk_sel_r == `SRC_TIMER && src_tick);
endmodule

// >>> uart_clksel_defines.svh
// Constants of the serial channel with clock-source selection and stop mode.
// Assumes inclusion by its bare name from the package and the design file.
//
// Functional notes
// - A 3-bit field picks the counter source: 0 the external serial clock pin, 1 to 6 the internal clock divided by 1, 2, 4, 8, 16 or 32, 7 the second timer output.
// - The clock-source register is read and written by software as one byte.
// - Reset clears the clock-source register to zero, which picks the external serial clock pin.
// - The channel has exactly two modes, stopped and asynchronous transfer.
// - The channel is stopped whenever both transmit and receive enables are zero.
// - While stopped, the transmit and receive pins belong to the general-purpose port.
// - While stopped, nothing shifts and the rate logic is frozen to save power.
// - The asynchronous mode sends and receives at once, one byte after a start bit.
// - The rate generator covers a wide range of rates, 31.25 kbps among them.
`ifndef UART_CLKSEL_DEFINES_SVH
`define UART_CLKSEL_DEFINES_SVH
// Register indices; byte address is four times the index
`define IDX_SERIAL_MODE_CONTROL 32'hFFFFF300
`define IDX_SERIAL_CLOCK_SOURCE_SELECT 32'hFFFFF31E
`define IDX_BAUD_DIVISOR 32'hFFFFF3F0
`define IDX_TX_DATA 32'hFFFFF3F1
`define IDX_RX_DATA 32'hFFFFF3F2
`define IDX_CHANNEL_STATUS 32'hFFFFF3F3
// Field positions
`define POS_TX_ENABLE_BIT 7
`define POS_RX_ENABLE_BIT 6
`define POS_STAT_TX_BUSY 0
`define POS_STAT_RX_VALID 1
`define POS_STAT_ACTIVE 2
// Reset values
`define RST_SERIAL_MODE_CONTROL 8'h00
`define RST_SERIAL_CLOCK_SOURCE_SELECT 3'h0
`define RST_BAUD_DIVISOR 8'h64
// Source codes
`define SRC_EXTERNAL 3'h0
`define SRC_TIMER 3'h7
`define SRC_DIV_TOP 3'h6
// Timing: oversampling ticks per bit, mid-bit point
`define OVERSAMPLE_LAST 4'hF
`define OVERSAMPLE_MID 4'h7
`define DATA_BITS_LAST 3'h7
`endif

// >>> uart_clksel_pkg.sv
// Types shared by the serial channel design.
// Assumes the constants header is on the include path.
`include "uart_clksel_defines.svh"
package uart_clksel_pkg;
   // Avalon-MM request from the master, carried as one bundle
   typedef struct packed {
      logic read;
      logic write;
      logic [31:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } avs_req_type;
   // Channel operating mode
   typedef enum logic {MODE_STOPPED, MODE_ASYNC} chan_mode_type;
   // Transmitter and receiver states
   typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_type;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_type;
endpackage
